/* core/ats_pkg.sv */
package ats_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] ATS_TRIG_SEL_OFS   = 12'h014;
   localparam logic [11:0] ATS_TRIG_STAT_OFS  = 12'h024;
   localparam logic [11:0] ATS_SW_START_OFS   = 12'h028;
   localparam logic [31:0] ATS_TRIG_SEL_RST   = 32'h0000_0000;
   localparam logic [31:0] ATS_TRIG_SEL_MASK  = 32'h0000_0FFF;
   localparam int          ATS_NUM_SEQ        = 3;
   localparam int          ATS_FIELD_W        = 4;
   localparam int          ATS_SEQ0_LSB       = 0;
   localparam int          ATS_SEQ1_LSB       = 4;
   localparam int          ATS_SEQ2_LSB       = 8;

   // ------------------------------------------------------------
   // trigger source codes
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ATS_SRC_SOFTWARE = 4'h0,
      ATS_SRC_COMP0    = 4'h1,
      ATS_SRC_COMP1    = 4'h2,
      ATS_SRC_EXT_PIN  = 4'h4,
      ATS_SRC_TIMER    = 4'h5,
      ATS_SRC_ALWAYS   = 4'hF
   } ats_src_t;

   localparam logic [1:0] ATS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] ATS_RESP_SLVERR = 2'h2;
endpackage

/* core/ats_trig_mux.sv */
`timescale 1ns/10ps
module ats_trig_mux
   import ats_pkg::*;
(
   input  wire logic [3:0] sel,
   input  wire logic       sw_start,
   input  wire logic       comp0_evt,
   input  wire logic       comp1_evt,
   input  wire logic       pin_evt,
   input  wire logic       timer_evt,
   input  wire logic       timer_trig_en,
   output logic            trig
);
   // ------------------------------------------------------------
   // source decode
   // ------------------------------------------------------------
   wire logic is_sw    = (sel == ATS_SRC_SOFTWARE);
   wire logic is_c0    = (sel == ATS_SRC_COMP0);
   wire logic is_c1    = (sel == ATS_SRC_COMP1);
   wire logic is_pin   = (sel == ATS_SRC_EXT_PIN);
   wire logic is_tmr   = (sel == ATS_SRC_TIMER);
   wire logic is_alw   = (sel == ATS_SRC_ALWAYS);
   // reserved codes match nothing, so trig stays low
   assign trig = (is_sw & sw_start) | (is_c0 & comp0_evt) | (is_c1 & comp1_evt)
               | (is_pin & pin_evt) | (is_tmr & timer_evt & timer_trig_en)
               | is_alw;
endmodule // ats_trig_mux

/* core/ats_trigger_select.sv */
`timescale 1ns/10ps
// Overview of operation
// - bits 11:8 read-write select the trigger source of sequencer 2
// - bits 7:4 read-write select the trigger source of sequencer 1
// - bits 3:0 read-write select the trigger source of sequencer 0
// - 0x0 software start (reset default), 0x1 comparator 0, 0x2 comparator 1
// - 0x4 starts sampling on an external pin event
// - 0x5 starts on timer event only when timer trigger enable set
// - 0xF keeps the sequencer permanently triggered
// - each sequencer has its own independent trigger source
module ats_trigger_select
   import ats_pkg::*;
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [11:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [11:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   comp0_evt,
   input  wire logic                   comp1_evt,
   input  wire logic                   external_trigger_pin,
   input  wire logic                   timer_evt,
   input  wire logic                   timer_trig_en,
   output logic [ats_pkg::ATS_NUM_SEQ-1:0] seq_trigger
);
   import ats_pkg::*;

   // ------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------
   logic pin_s1_reg;
   logic pin_s2_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
      end else begin
         pin_s1_reg <= external_trigger_pin;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // word match only; the two low address bits do not take part
   function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] ofs);
      return (addr[11:2] == ofs[11:2]);
   endfunction

   // ------------------------------------------------------------
   // write channel
   // ------------------------------------------------------------
   logic [11:0] aw_addr_reg;
   logic        aw_have_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        w_have_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic [11:0] trig_sel_reg;
   logic [2:0]  sw_start_reg;
   logic        awready_reg;
   logic        wready_reg;

   wire logic aw_take      = s_axi_awvalid & awready_reg;
   wire logic w_take       = s_axi_wvalid & wready_reg;
   wire logic wr_fire      = aw_have_reg & w_have_reg & ~bvalid_reg;
   wire logic wr_sel       = addr_hit(aw_addr_reg, ATS_TRIG_SEL_OFS);
   wire logic wr_sw        = addr_hit(aw_addr_reg, ATS_SW_START_OFS);
   wire logic wr_stat      = addr_hit(aw_addr_reg, ATS_TRIG_STAT_OFS);
   wire logic aw_have_next = aw_take | (aw_have_reg & ~wr_fire);
   wire logic w_have_next  = w_take | (w_have_reg & ~wr_fire);
   wire logic bvalid_next  = wr_fire | (bvalid_reg & ~s_axi_bready);
   wire logic wr_ok    = wr_sel | wr_sw | wr_stat;

   // byte-lane merge; fields only live in lanes 0 and 1
   wire logic [11:0] sel_merge = {w_strb_reg[1] ? w_data_reg[11:8] : trig_sel_reg[11:8],
                                  w_strb_reg[0] ? w_data_reg[7:0]  : trig_sel_reg[7:0]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
      end else if (aw_take) begin
         aw_have_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (w_take) begin
         w_have_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= ATS_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_ok ? ATS_RESP_OKAY : ATS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ready is a flop, so it is worked out from the next state of the holding registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
      end else begin
         awready_reg <= ~aw_have_next & ~bvalid_next;
         wready_reg  <= ~w_have_next & ~bvalid_next;
      end
   end

   // ------------------------------------------------------------
   // trigger select register
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_sel_reg <= ATS_TRIG_SEL_RST[11:0];
      end else if (wr_fire && wr_sel) begin
         trig_sel_reg <= sel_merge;
      end
   end

   // software start is a one-cycle pulse per written bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_start_reg <= 3'h0;
      end else if (wr_fire && wr_sw && w_strb_reg[0]) begin
         sw_start_reg <= w_data_reg[2:0];
      end else begin
         sw_start_reg <= 3'h0;
      end
   end

   // ------------------------------------------------------------
   // per-sequencer trigger mux
   // ------------------------------------------------------------
   logic [ATS_NUM_SEQ-1:0] trig_w;
   logic [ATS_NUM_SEQ-1:0] trig_reg;
   localparam int LSB [ATS_NUM_SEQ] = '{ATS_SEQ0_LSB, ATS_SEQ1_LSB, ATS_SEQ2_LSB};

   generate
      for (genvar i = 0; i < ATS_NUM_SEQ; i++) begin : g_seq
         ats_trig_mux u_mux (
            .sel           (trig_sel_reg[LSB[i] +: ATS_FIELD_W]),
            .sw_start      (sw_start_reg[i]),
            .comp0_evt     (comp0_evt),
            .comp1_evt     (comp1_evt),
            .pin_evt       (pin_s2_reg),
            .timer_evt     (timer_evt),
            .timer_trig_en (timer_trig_en),
            .trig          (trig_w[i])
         );
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_reg <= '0;
      end else begin
         trig_reg <= trig_w;
      end
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        arready_reg;

   wire logic ar_take     = s_axi_arvalid & arready_reg;
   wire logic rd_sel      = addr_hit(s_axi_araddr, ATS_TRIG_SEL_OFS);
   wire logic rd_stat     = addr_hit(s_axi_araddr, ATS_TRIG_STAT_OFS);
   wire logic rd_sw       = addr_hit(s_axi_araddr, ATS_SW_START_OFS);
   wire logic rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
   wire logic [31:0] rd_mux = rd_sel  ? {20'h00000, trig_sel_reg} :
                              rd_stat ? {29'h00000000, trig_reg} : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= ATS_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_mux;
         rresp_reg  <= (rd_sel | rd_stat | rd_sw) ? ATS_RESP_OKAY : ATS_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
      end else begin
         arready_reg <= ~rvalid_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign seq_trigger   = trig_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_sel_lane(int lane);
      wr_fire && wr_sel && w_strb_reg[lane];
   endsequence
   sequence s_sw_seq0;
      sw_start_reg[0] && trig_sel_reg[3:0] == 4'h0;
   endsequence

   seq2_field_a: assert property (s_sel_lane(1) |=>
      trig_sel_reg[11:8] == $past(w_data_reg[11:8]))
      else $error("seq2 field not stored");
   seq1_field_a: assert property (wr_fire && wr_sel && w_strb_reg[0] |=>
      trig_sel_reg[7:4] == $past(w_data_reg[7:4]))
      else $error("seq1 field not stored");
   seq0_field_a: assert property (wr_fire && wr_sel && w_strb_reg[0] |=>
      trig_sel_reg[3:0] == $past(w_data_reg[3:0]))
      else $error("seq0 field not stored");
   comp0_path_a: assert property (trig_sel_reg[3:0] == 4'h1 && comp0_evt |=>
      seq_trigger[0])
      else $error("comparator 0 not passed");
   pin_path_a: assert property (
      trig_sel_reg[3:0] == 4'h4 && $stable(trig_sel_reg) && external_trigger_pin [*3]
      |=> seq_trigger[0])
      else $error("pin event not passed");
   timer_gate_a: assert property (trig_sel_reg[7:4] == 4'h5 && !timer_trig_en |=>
      !seq_trigger[1])
      else $error("timer fired without enable");
   always_on_a: assert property (trig_sel_reg[11:8] == 4'hF |=> seq_trigger[2])
      else $error("always mode not continuous");
   reserved_off_a: assert property (trig_sel_reg[3:0] == 4'h3 |=> !seq_trigger[0])
      else $error("reserved code triggered");
   indep_seq_a: assert property (trig_sel_reg[3:0] == 4'hF &&
      trig_sel_reg[7:4] == 4'h3 |=> seq_trigger[0] && !seq_trigger[1])
      else $error("sequencers not independent");
   lane_keep_a: assert property (wr_fire && wr_sel && !w_strb_reg[1] |=>
      $stable(trig_sel_reg[11:8]))
      else $error("seq2 field changed without its lane");
   comp1_path_a: assert property (trig_sel_reg[7:4] == 4'h2 && comp1_evt |=>
      seq_trigger[1])
      else $error("comparator 1 not passed");
   sw_start_a: assert property (s_sw_seq0 |=> seq_trigger[0])
      else $error("software start not passed");
   sw_single_a: assert property (sw_start_reg != 3'h0 |=> sw_start_reg == 3'h0)
      else $error("software start longer than one cycle");
   sw_gate_a: assert property (sw_start_reg[1] && trig_sel_reg[7:4] == 4'h1 &&
      !comp0_evt |=> !seq_trigger[1])
      else $error("software start passed on a comparator field");
   timer_path_a: assert property (trig_sel_reg[11:8] == 4'h5 && timer_evt &&
      timer_trig_en |=> seq_trigger[2])
      else $error("timer event not passed");
   reserved_hi_a: assert property (trig_sel_reg[7:4] inside {[4'h6:4'hE]} |=>
      !seq_trigger[1])
      else $error("upper reserved code triggered");
endmodule // ats_trigger_select

/* verification/ats_trigger_select_test.sv */
`timescale 1ns/10ps
module ats_trigger_select_test;
   import ats_pkg::*;
   // ------------------------------------------------------------
   // stimulus and design
   // ------------------------------------------------------------
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        comp0_evt = 0, comp1_evt = 0, external_trigger_pin = 0;
   logic        timer_evt = 0, timer_trig_en = 0;
   logic [2:0]  seq_trigger;
   int          fails = 0, n_compared = 0;
   int          pcnt [3];
   int          base [3];
   logic [1:0]  resp;
   logic [31:0] rd;
   logic        hit;

   always #12.5 aclk = ~aclk;

   ats_trigger_select dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comp0_evt, .comp1_evt,
      .external_trigger_pin, .timer_evt, .timer_trig_en, .seq_trigger);

   // counts trigger cycles; software start is a one-cycle pulse
   always @(negedge aclk) begin
      for (int i = 0; i < 3; i++) if (seq_trigger[i] === 1'b1) pcnt[i]++;
   end

   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   // each request stands until the rising edge at which its ready is seen high
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // sources: {timer_trig_en, timer_evt, pin, comp1, comp0}; pin needs 3 cycles
   task automatic drive_src(input logic [4:0] v);
      @(posedge aclk);
      {timer_trig_en, timer_evt, external_trigger_pin, comp1_evt, comp0_evt} <= v;
      repeat (5) @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic finish_test;
      if (fails == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   localparam logic [4:0] SRC_TAB [5] = '{5'h01, 5'h02, 5'h04, 5'h18, 5'h08};

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(ATS_TRIG_SEL_OFS, rd, resp);
      chk(rd, ATS_TRIG_SEL_RST);
      chk({29'h0, seq_trigger}, 32'h0);
      // every code against each comparator, pin and timer source; timer without enable must not fire
      for (int c = 0; c < 16; c++) begin
         axi_wr(ATS_TRIG_SEL_OFS, {20'h0, c[3:0], c[3:0], c[3:0]}, resp);
         axi_rd(ATS_TRIG_SEL_OFS, rd, resp);
         chk(rd, {20'h0, c[3:0], c[3:0], c[3:0]});
         for (int s = 0; s < 5; s++) begin
            drive_src(SRC_TAB[s]);
            hit = (c == 15) || (c == 1 && s == 0) || (c == 2 && s == 1) ||
                  (c == 4 && s == 2) || (c == 5 && s == 3);
            chk({29'h0, seq_trigger}, {29'h0, {3{hit}}});
         end
         drive_src(5'h00);
         chk({29'h0, seq_trigger}, {29'h0, {3{c == 15}}});
      end
      // upper bits are not stored
      axi_wr(ATS_TRIG_SEL_OFS, 32'hFFFF_F421, resp);
      axi_rd(ATS_TRIG_SEL_OFS, rd, resp);
      chk(rd, 32'h0000_0421);
      // independent selections: seq0 comp0, seq1 comp1, seq2 pin
      drive_src(5'h01);
      chk({29'h0, seq_trigger}, 32'h1);
      drive_src(5'h02);
      chk({29'h0, seq_trigger}, 32'h2);
      drive_src(5'h04);
      chk({29'h0, seq_trigger}, 32'h4);
      drive_src(5'h00);
      // software start fires only where the field holds the default code
      axi_wr(ATS_TRIG_SEL_OFS, 32'h0000_0010, resp);
      base = pcnt;
      axi_wr(ATS_SW_START_OFS, 32'h7, resp);
      chk({30'h0, resp}, {30'h0, ATS_RESP_OKAY});
      repeat (4) @(posedge aclk);
      chk(pcnt[0] - base[0], 1);
      chk(pcnt[1] - base[1], 0);
      chk(pcnt[2] - base[2], 1);
      // unmapped place: error response, no effect
      axi_wr(12'h100, 32'hFFFF_FFFF, resp);
      chk({30'h0, resp}, {30'h0, ATS_RESP_SLVERR});
      axi_rd(12'h100, rd, resp);
      chk({30'h0, resp}, {30'h0, ATS_RESP_SLVERR});
      axi_rd(ATS_TRIG_SEL_OFS, rd, resp);
      chk(rd, 32'h0000_0010);
      // a write without lane 1 leaves the seq2 field alone
      s_axi_wstrb <= 4'h1;
      axi_wr(ATS_TRIG_SEL_OFS, 32'h0000_0F32, resp);
      s_axi_wstrb <= 4'hF;
      axi_rd(ATS_TRIG_SEL_OFS, rd, resp);
      chk(rd, 32'h0000_0032);
      // reset in mid-run restores the default code
      axi_wr(ATS_TRIG_SEL_OFS, 32'h0000_0FFF, resp);
      axi_rd(ATS_TRIG_STAT_OFS, rd, resp);
      chk(rd, 32'h0000_0007);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk({29'h0, seq_trigger}, 32'h0);
      axi_rd(ATS_TRIG_SEL_OFS, rd, resp);
      chk(rd, ATS_TRIG_SEL_RST);
      chk({29'h0, seq_trigger}, 32'h0);
      finish_test();
   end

   // the run needs about 800 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      finish_test();
   end
endmodule // ats_trigger_select_test
